// File: verilog/wwd_core.sv
// windowed watchdog timer: option byte, service register, counter and reset request
//
// Overview of operation
// R01: with interval interrupt chosen, pulse it at 75% of period plus half tick.
// R02: window code 01/10/11 opens 50/75/100% of period; code 00 is prohibited.
// R03: run-at-reset option decides whether counting starts after reset release.
// R04: period selector picks 2^6,2^7,2^8,2^9,2^11,2^13,2^14,2^16 watchdog ticks.
// R05: standby option decides whether counting continues in halt, stop, snooze.
// R06: byte write of key ACH inside the open window clears and restarts counter.
// R07: first service write after reset ignores the window check.
// R08: while counting, a service write in the closed window forces internal reset.
// R09: while counting, a non-key value or bit write forces internal reset.
// R10: service register reads 1AH after reset if run-at-reset set, else 9AH.
// R11: counter reaching overflow without valid service forces internal reset.
// R12: configuration comes from the option byte at reset; runtime writes cannot change it.
// R13: software avoids servicing in the scaled prohibited span of the 75% window.
// R14: software services only with 8-bit key writes, never bit instructions.
// R15: closed window covers the start of each period, open window its end.
// R16: a watchdog reset reinitialises counter, window tracking and service register.
`timescale 1ns/1ps
module wwd_core
  import wwd_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // non-volatile option byte, sampled while reset is low
  input  wire logic [7:0] option_byte,
  // cpu data space access
  input  wire wwd_bus_s   bus,
  output logic [7:0]      rd_data,
  // processor low-power state
  input  wire logic       standby,
  // results
  output logic            internal_reset,
  output logic            interval_irq,
  output logic            counting
);

  wwd_state_s s;
  wwd_state_s next_s;
  logic       tick;
  logic       half_tick;
  logic       run_en;
  logic       svc_clear;

  // overflow length in watchdog ticks
  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] sel);
    period_of = CNT_W'(1) << PERIOD_EXP[sel]; // R04
  endfunction : period_of

  // count value at which the open window begins
  function automatic logic [CNT_W-1:0] open_from(input wwd_opt_s o);
    logic [CNT_W-1:0] p;
    p = period_of(o.overflow_period_sel);
    case (o.window_size)
      WWD_WIN_50: open_from = p >> 1; // R02 R15
      WWD_WIN_75: open_from = p >> 2; // R02 R15
      // prohibited code behaves as fully open rather than tripping on every write
      default:    open_from = '0;     // R02
    endcase
  endfunction : open_from

  // reset state built from a given option byte
  function automatic wwd_state_s fresh(input wwd_opt_s o);
    wwd_state_s f;
    f            = '0;
    f.opt        = o; // R12
    f.mode       = o.count_at_reset ? WWD_COUNTING : WWD_STOPPED; // R03
    f.service_register = o.count_at_reset ? SVC_RST_RUN : SVC_RST_STOP; // R10
    fresh        = f;
  endfunction : fresh

  // standby halts counting unless the option keeps it alive
  assign run_en = (s.mode == WWD_COUNTING) && (!standby || s.opt.standby_count_keep); // R05

  wwd_tick #(
    .DIV       (DIV)
  ) u_tick (
    .clk       (clk),
    .rst_b     (rst_b),
    .run       (run_en),
    .restart   (svc_clear),
    .tick      (tick),
    .half_tick (half_tick)
  );

  always_comb begin
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] irq_at;
    logic             svc_write;
    logic             window_open;
    logic             trip;
    period      = period_of(s.opt.overflow_period_sel);
    irq_at      = CNT_W'(period - (period >> 2));
    svc_write   = bus.wr && (bus.addr == SVC_ADDR);
    window_open = (s.cnt >= open_from(s.opt)); // R15
    trip        = 1'b0;
    svc_clear   = 1'b0;
    next_s           = s;
    next_s.rst_pulse = 1'b0;
    next_s.irq_pulse = 1'b0;

    // reads return registered data one cycle later
    if (bus.rd) begin
      if (bus.addr == OPT_ADDR) begin
        next_s.rd_data = s.opt;
      end else if (bus.addr == SVC_ADDR) begin
        next_s.rd_data = s.service_register;
      end else begin
        next_s.rd_data = RD_NONE;
      end
    end

    if (s.mode == WWD_COUNTING) begin
      if (svc_write) begin
        // any service write realigns the divider, so a refused one restarts from tick zero
        svc_clear = 1'b1; // R16
        if (bus.bit_op || bus.wdata != SVC_KEY) begin
          trip = 1'b1; // R09
        end else if (s.first_done && !window_open) begin
          trip = 1'b1; // R08
        end else begin
          svc_clear                = 1'b1; // R06 R07
          next_s.cnt               = '0; // R06
          next_s.first_done        = 1'b1; // R07
          next_s.service_register  = bus.wdata;
        end
      end else if (tick) begin
        if (s.cnt == CNT_W'(period - CNT_W'(1))) begin
          trip = 1'b1; // R11
        end else begin
          next_s.cnt = CNT_W'(s.cnt + CNT_W'(1));
        end
      end else if (half_tick && s.opt.interval_irq_use && s.cnt == irq_at) begin
        // half a tick past the three-quarter mark
        next_s.irq_pulse = 1'b1; // R01
      end
    end else if (svc_write) begin
      // stopped counter: writes only land in the register, no reset source
      next_s.service_register = bus.wdata;
    end

    // option byte and read data are kept, everything else starts over
    if (trip) begin
      next_s           = fresh(s.opt); // R16
      next_s.rst_pulse = 1'b1;
      next_s.rd_data   = s.rd_data;
    end

    if (!rst_b) begin
      next_s = fresh(wwd_opt_s'(option_byte)); // R12
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign rd_data        = s.rd_data;
  assign internal_reset = s.rst_pulse; // R08 R09 R11
  assign interval_irq   = s.irq_pulse; // R01
  assign counting       = (s.mode == WWD_COUNTING);

endmodule : wwd_core

// File: verilog/wwd_pkg.sv
// constants and types shared by the windowed watchdog files
package wwd_pkg;

  // timing: core clock and nominal watchdog count clock
  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned WDT_HZ   = 17_250;
  localparam int unsigned TICK_DIV = CLK_HZ / WDT_HZ;

  // addresses on the cpu data space
  localparam int unsigned ADDR_W   = 20;
  localparam int unsigned CNT_W    = 17;
  localparam logic [19:0] OPT_ADDR = 20'h000C0;
  localparam logic [19:0] SVC_ADDR = 20'hFFFAB;

  // service register values
  localparam logic [7:0] SVC_KEY      = 8'hAC;
  localparam logic [7:0] SVC_RST_RUN  = 8'h1A;
  localparam logic [7:0] SVC_RST_STOP = 8'h9A;
  localparam logic [7:0] RD_NONE      = 8'h00;

  // overflow exponents for period selector codes 0..7
  localparam logic [4:0] PERIOD_EXP [8] = '{5'h06, 5'h07, 5'h08, 5'h09,
                                            5'h0B, 5'h0D, 5'h0E, 5'h10};

  typedef enum logic [1:0] {
    WWD_WIN_BAD = 2'b00,
    WWD_WIN_50  = 2'b01,
    WWD_WIN_75  = 2'b10,
    WWD_WIN_100 = 2'b11
  } wwd_win_e;

  typedef enum logic [0:0] {
    WWD_STOPPED  = 1'b0,
    WWD_COUNTING = 1'b1
  } wwd_mode_e;

  // option byte, bit 7 down to bit 0
  typedef struct packed {
    logic       interval_irq_use;
    wwd_win_e   window_size;
    logic       count_at_reset;
    logic [2:0] overflow_period_sel;
    logic       standby_count_keep;
  } wwd_opt_s;

  // cpu access to the data space
  typedef struct packed {
    logic [19:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [7:0]  wdata;
  } wwd_bus_s;

  typedef struct packed {
    wwd_opt_s         opt;
    wwd_mode_e        mode;
    logic [CNT_W-1:0] cnt;
    logic             first_done;
    logic [7:0]       service_register;
    logic [7:0]       rd_data;
    logic             rst_pulse;
    logic             irq_pulse;
  } wwd_state_s;

endpackage : wwd_pkg

// File: verilog/wwd_tick.sv
// divider making the watchdog count clock enables from the core clock
`timescale 1ns/1ps
module wwd_tick
  import wwd_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control
  input  wire logic run,
  input  wire logic restart,
  // enables
  output logic      tick,
  output logic      half_tick
);

  localparam logic [15:0] LAST = 16'(DIV - 1);
  localparam logic [15:0] HALF = 16'(DIV / 2 - 1);

  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;

  always_comb begin
    next_div_cnt = div_cnt;
    if (restart) begin
      next_div_cnt = '0;
    end else if (run) begin
      next_div_cnt = (div_cnt == LAST) ? '0 : 16'(div_cnt + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // held off while stopped, so standby freezes the fraction of a period too
  assign tick      = run && !restart && (div_cnt == LAST);
  assign half_tick = run && !restart && (div_cnt == HALF);

endmodule : wwd_tick

// File: sim/wwd_properties.sv
// assertions on the windowed watchdog ports
`timescale 1ns/1ps
module wwd_properties
  import wwd_pkg::*;
#(
  parameter int unsigned DIV = 4
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] option_byte,
  input wire wwd_bus_s   bus,
  input wire logic [7:0] rd_data,
  input wire logic       standby,
  input wire logic       internal_reset,
  input wire logic       interval_irq,
  input wire logic       counting
);
  logic [7:0]  opt;
  logic [19:0] cyc;
  logic        first;
  int unsigned per;
  wire svc  = bus.wr && bus.addr == SVC_ADDR;
  wire good = svc && bus.wdata == SVC_KEY && !bus.bit_op;
  assign per = DIV << PERIOD_EXP[opt[3:1]];
  // cycles since the last clear; only bounds are checked, exact tick phase is the design's
  always_ff @(posedge clk) begin
    if (!rst_b) opt <= option_byte;
    cyc <= (!rst_b || internal_reset || good) ? 20'h00000 : cyc + 20'h00001;
    first <= rst_b && !internal_reset && (first || svc);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  bad_key_a: assert property (counting && svc && bus.wdata != SVC_KEY |=> internal_reset)
    else $error("wrong key gave no reset");
  bit_write_a: assert property (counting && svc && bus.bit_op |=> internal_reset)
    else $error("bit write gave no reset");
  closed_win_a: assert property (counting && first && good && cyc < 8 * DIV &&
    opt[6:5] inside {2'b01, 2'b10} |=> internal_reset) else $error("closed window write passed");
  first_free_a: assert property (counting && !first && good |=> !internal_reset)
    else $error("first write was refused");
  open_win_a: assert property (counting && good && opt[6:5] == 2'b11 && cyc < 32 * DIV
    |=> !internal_reset) else $error("open window write refused");
  stopped_quiet_a: assert property (!counting |=> !internal_reset)
    else $error("reset while stopped");
  early_ovf_a: assert property (internal_reset |-> $past(svc) || cyc >= per - DIV)
    else $error("reset before overflow");
  irq_time_a: assert property (interval_irq |-> cyc >= per / 4 * 3 &&
    cyc <= per / 4 * 3 + DIV + 2) else $error("interval irq off time");
  irq_off_a: assert property (!opt[7] |-> !interval_irq)
    else $error("interval irq not enabled");
  opt_read_a: assert property (bus.rd && !bus.wr && bus.addr == OPT_ADDR |=> rd_data == opt)
    else $error("option byte read wrong");
  cover property (interval_irq);
  cover property (internal_reset && cyc > 20'h00040);
  cover property (standby ##1 standby[*8] ##1 internal_reset);
endmodule : wwd_properties

// File: sim/tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module tb
  import wwd_pkg::*;
;
  localparam int D = 4;
  logic        clk;
  logic        rst_b;
  logic [7:0]  option_byte;
  wwd_bus_s    bus;
  logic [7:0]  rd_data;
  logic        standby;
  logic        internal_reset;
  logic        interval_irq;
  logic        counting;
  int          fail_count;
  int          samples_checked;
  int          n;
  int          ex [5] = '{6, 7, 8, 9, 11};
  logic [15:0] lf;
  wwd_core #(.DIV(D)) wwd_core_i (.clk(clk), .rst_b(rst_b), .option_byte(option_byte),
    .bus(bus), .rd_data(rd_data), .standby(standby), .internal_reset(internal_reset),
    .interval_irq(interval_irq), .counting(counting));
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic boot(logic [7:0] o);
    @(posedge clk);
    rst_b <= 1'b0;
    option_byte <= o;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
  endtask : boot
  // one byte access; results settle one cycle after the request edge
  task automatic acc(logic [19:0] a, logic w, logic b, logic [7:0] d);
    @(posedge clk);
    bus <= {a, w, !w, b, d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : acc
  task automatic wait_ev(logic irq, int lim);
    n = 0;
    while ((irq ? interval_irq : internal_reset) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_ev
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // longest test run is well under 60000 cycles
  initial begin
    #(40 * 90000);
    fail_count++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    option_byte = 8'h00;
    bus = '0;
    standby = 1'b0;
    lf = 16'hD396;
    for (int r = 0; r < 2; r++) begin
      boot({3'b001, r[0], 4'h0});
      acc(SVC_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rd_data, r[0] ? 8'h1A : 8'h9A);
      chk(8'(counting), 8'(r[0]));
      acc(OPT_ADDR, 1'b1, 1'b0, 8'hFF);
      acc(OPT_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rd_data, {3'b001, r[0], 4'h0});
    end
    // stopped counter only stores service writes
    boot(8'h20);
    acc(SVC_ADDR, 1'b1, 1'b0, 8'h55);
    wait_ev(1'b0, 200);
    chk(8'(n), 8'hC8);
    acc(SVC_ADDR, 1'b0, 1'b0, 8'h00);
    chk(rd_data, 8'h55);
    $display("done: reset values and stopped mode");
    for (int s = 0; s < 5; s++) begin
      boot({4'b0011, s[2:0], 1'b0});
      acc(SVC_ADDR, 1'b1, 1'b0, SVC_KEY);
      chk(8'(internal_reset), 8'h00);
      wait_ev(1'b0, 70000);
      chk(8'(n >= (D << ex[s]) - 3 && n <= (D << ex[s]) + 3), 8'h01);
    end
    $display("done: overflow periods");
    for (int k = 0; k < 3; k++) begin
      boot(8'h30);
      if (k != 2) acc(SVC_ADDR, 1'b1, 1'b0, SVC_KEY);
      lf = lfsr(lf);
      acc(SVC_ADDR, 1'b1, k == 1, k < 2 ? SVC_KEY : (lf[7:0] == 8'hAC ? 8'h00 : lf[7:0]));
      chk(8'(internal_reset), 8'h01);
      acc(SVC_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rd_data, 8'h1A);
    end
    $display("done: bad service writes");
    // code 00 is prohibited; the block treats it as fully open
    for (int w = 0; w < 4; w++) begin
      boot({1'b0, w[1:0], 5'b10000});
      repeat (4) begin
        // 48 ticks keeps clear of the avoided span of the 75% window
        repeat (48 * D) @(posedge clk);
        acc(SVC_ADDR, 1'b1, 1'b0, SVC_KEY);
        chk(8'(internal_reset), 8'h00);
      end
      repeat (24 * D) @(posedge clk);
      acc(SVC_ADDR, 1'b1, 1'b0, SVC_KEY);
      chk(8'(internal_reset), 8'(w == 1));
    end
    $display("done: window sizes");
    boot(8'hF0);
    wait_ev(1'b1, 300);
    chk(8'(n >= 48 * D + D / 2 - 3 && n <= 48 * D + D / 2 + 4), 8'h01);
    boot(8'h70);
    wait_ev(1'b1, 250);
    chk(8'(n), 8'hFA);
    standby <= 1'b1;
    wait_ev(1'b0, 400);
    chk(8'(n == 400), 8'h01);
    boot(8'h71);
    wait_ev(1'b0, 400);
    chk(8'(n >= 64 * D - 3 && n <= 64 * D + 4), 8'h01);
    standby <= 1'b0;
    $display("done: interval irq and standby");
    final_report();
  end
endmodule : tb
bind wwd_core wwd_properties #(.DIV(DIV)) wwd_properties_i (.clk(clk), .rst_b(rst_b),
  .option_byte(option_byte), .bus(bus), .rd_data(rd_data), .standby(standby),
  .internal_reset(internal_reset), .interval_irq(interval_irq), .counting(counting));
